// ---- pepw_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module pepw_host (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// User command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [12:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic cmd_last,
	// User read data
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [7:0] rd_data,
	// Status
	output logic busy,
	output logic page_err,
	// Device pins
	output logic [12:0] mem_addr,
	output logic chip_select_n,
	output logic output_drive_enable_n,
	output logic write_strobe_n,
	input wire logic [7:0] mem_dq_i,
	output logic [7:0] mem_dq_o,
	output logic mem_dq_oe
);

	// =====================================================================
	// States
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_RSETUP = 7'h02,
		ST_RHOLD = 7'h04,
		ST_WSETUP = 7'h08,
		ST_WPULSE = 7'h10,
		ST_WRECOV = 7'h20,
		ST_BUSY = 7'h40
	} pepw_state_t;

	pepw_state_t state_r, state_nxt;
	logic [pepw_pkg::CNT_W-1:0] tmr_r, tmr_nxt;
	logic [pepw_pkg::CNT_W-1:0] win_r;
	logic [5:0] loads_r;
	logic [7:0] page_r;
	logic [7:0] last_data_r;
	logic [12:0] last_addr_r;
	logic poll_r;
	logic [7:0] dq_s1_r, dq_s2_r;
	logic [7:0] rdat_r;
	logic rpush_r;
	logic busy_r, page_err_r;
	logic [12:0] addr_r;
	logic cs_n_r, oe_n_r, we_n_r, dq_oe_r;
	logic [7:0] dq_o_r;
	logic buf_ready;

	// =====================================================================
	// Decode
	wire is_write = (cmd_op == pepw_pkg::CMD_WRITE);
	wire is_poll = (cmd_op == pepw_pkg::CMD_POLL);
	wire [7:0] cmd_page = cmd_addr[12:pepw_pkg::PAGE_LSB];
	wire in_page = (loads_r != 6'h00);
	wire page_bad = is_write && in_page && (cmd_page != page_r);
	wire page_full = is_write && (loads_r == 6'(pepw_pkg::PAGE_BYTES));
	// Window still open; next load must fall inside it
	wire win_open = in_page && (win_r < 16'(pepw_pkg::BYTE_LOAD_WINDOW_CYC - 8));
	// While the device programs only poll reads go out
	wire cmd_ok = busy_r ? is_poll : (is_write ? (!page_bad && !page_full) : 1'b1);
	wire accept = cmd_valid && (state_r == ST_IDLE) && buf_ready && (!is_write || !in_page
		|| win_open) && cmd_ok;
	wire tmr_done = (tmr_r == 16'h0000);
	wire poll_done = (dq_s2_r[pepw_pkg::POLL_BIT] == last_data_r[pepw_pkg::POLL_BIT]);

	assign cmd_ready = accept;

	// =====================================================================
	// Next-state logic
	always_comb begin
		state_nxt = state_r;
		tmr_nxt = tmr_done ? tmr_r : tmr_r - 16'h0001;
		case (state_r)
			ST_IDLE: begin
				if (accept) begin
					state_nxt = is_write ? ST_WSETUP : ST_RSETUP;
					tmr_nxt = 16'(pepw_pkg::SETUP_CYC);
				end
			end
			ST_RSETUP: begin
				if (tmr_done) begin
					state_nxt = ST_RHOLD;
					tmr_nxt = 16'(pepw_pkg::ACCESS_CYC + 2);
				end
			end
			ST_RHOLD: begin
				if (tmr_done) begin
					state_nxt = ST_BUSY;
					tmr_nxt = 16'(pepw_pkg::HIZ_CYC);
				end
			end
			ST_WSETUP: begin
				if (tmr_done) begin
					state_nxt = ST_WPULSE;
					tmr_nxt = 16'(pepw_pkg::PULSE_CYC);
				end
			end
			ST_WPULSE: begin
				if (tmr_done) begin
					state_nxt = ST_WRECOV;
					tmr_nxt = 16'(pepw_pkg::RECOV_CYC);
				end
			end
			ST_WRECOV, ST_BUSY: begin
				if (tmr_done) state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// =====================================================================
	// Sequencer registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			tmr_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	// Pin drive; reset parks strobes high to inhibit writes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cs_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			we_n_r <= 1'b1;
			dq_oe_r <= 1'b0;
			addr_r <= 13'h0000;
			dq_o_r <= 8'h00;
		end else begin
			if (accept) begin
				// Polls always target the last loaded byte, the only one that inverts
				addr_r <= is_poll ? last_addr_r : cmd_addr;
				dq_o_r <= cmd_wdata;
				cs_n_r <= 1'b0;
				oe_n_r <= is_write;
				dq_oe_r <= is_write;
			end
			// Write strobe falls last, after address settles
			if (state_r == ST_WSETUP && tmr_done) we_n_r <= 1'b0;
			// Strobe rises first; data stays driven through recovery
			if (state_r == ST_WPULSE && tmr_done) we_n_r <= 1'b1;
			if (state_r == ST_WRECOV && tmr_done) begin
				cs_n_r <= 1'b1;
				dq_oe_r <= 1'b0;
				oe_n_r <= 1'b1;
			end
			// Output enable and select rise together to end a read
			if (state_r == ST_RHOLD && tmr_done) begin
				oe_n_r <= 1'b1;
				cs_n_r <= 1'b1;
			end
		end
	end

	// Data pin synchroniser, second stage only is read
	always_ff @(posedge mclk) begin
		dq_s1_r <= mem_dq_i;
		dq_s2_r <= dq_s1_r;
	end

	// Read capture into buffer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rpush_r <= 1'b0;
			rdat_r <= 8'h00;
		end else begin
			rpush_r <= (state_r == ST_RHOLD) && tmr_done;
			if ((state_r == ST_RHOLD) && tmr_done) rdat_r <= dq_s2_r;
		end
	end

	// Page, window and programming tracking
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			loads_r <= 6'h00;
			page_r <= 8'h00;
			win_r <= 16'h0000;
			busy_r <= 1'b0;
			poll_r <= 1'b0;
			page_err_r <= 1'b0;
			last_data_r <= 8'h00;
			last_addr_r <= 13'h0000;
		end else begin
			page_err_r <= cmd_valid && (page_bad || page_full) && !busy_r;
			if (accept && is_write) begin
				loads_r <= loads_r + 6'h01;
				page_r <= cmd_page;
				last_data_r <= cmd_wdata;
				last_addr_r <= cmd_addr;
				win_r <= 16'h0000;
			end else if (in_page) begin
				if (win_r == 16'(pepw_pkg::BYTE_LOAD_WINDOW_CYC)) begin
					// Silence past the window starts programming
					loads_r <= 6'h00;
					busy_r <= 1'b1;
				end else begin
					win_r <= win_r + 16'h0001;
				end
			end
			// Held through the read so a plain read cannot end programming
			if (accept) poll_r <= is_poll;
			if ((state_r == ST_RHOLD) && tmr_done && busy_r && poll_r && poll_done) begin
				busy_r <= 1'b0;
			end
		end
	end

	pepw_buf u_buf (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(rpush_r),
		.in_ready(buf_ready),
		.in_data(rdat_r),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// Outputs straight from flip-flops
	assign busy = busy_r;
	assign page_err = page_err_r;
	assign mem_addr = addr_r;
	assign chip_select_n = cs_n_r;
	assign output_drive_enable_n = oe_n_r;
	assign write_strobe_n = we_n_r;
	assign mem_dq_o = dq_o_r;
	assign mem_dq_oe = dq_oe_r;

	// =====================================================================
	// Checks
	a_write_oe_high: assert property (@(posedge mclk) disable iff (!rst_n)
		!we_n_r |-> (oe_n_r && !cs_n_r && dq_oe_r)) else $error("strobe low without write");
	a_read_no_drive: assert property (@(posedge mclk) disable iff (!rst_n)
		!oe_n_r |-> (!cs_n_r && !dq_oe_r)) else $error("read with data driven");
	a_page_limit: assert property (@(posedge mclk) disable iff (!rst_n)
		loads_r <= 6'(pepw_pkg::PAGE_BYTES)) else $error("page load count above limit");
	a_window_busy: assert property (@(posedge mclk) disable iff (!rst_n)
		(in_page && !accept && win_r == 16'(pepw_pkg::BYTE_LOAD_WINDOW_CYC)) |=> busy_r)
		else $error("window expiry did not mark busy");
	a_busy_poll_only: assert property (@(posedge mclk) disable iff (!rst_n)
		busy_r |-> (we_n_r && !dq_oe_r)) else $error("write driven while busy");
	a_strobe_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(we_n_r) |-> !we_n_r [*2]) else $error("strobe pulse too short");
	a_read_end: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(rpush_r) |-> oe_n_r) else $error("read not ended at capture");
	a_idle_inhibit: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_r == ST_IDLE) |-> (we_n_r && cs_n_r)) else $error("idle without inhibit");
	c_write: cover property (@(posedge mclk) disable iff (!rst_n) accept && is_write);
	c_prog: cover property (@(posedge mclk) disable iff (!rst_n) $rose(busy_r));
	c_done: cover property (@(posedge mclk) disable iff (!rst_n) $fell(busy_r));

endmodule : pepw_host

`default_nettype wire

// ---- pepw_pkg.sv ----
`default_nettype none

package pepw_pkg;

	// =====================================================================
	// Device geometry
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int PAGE_LSB = 5;
	localparam int PAGE_BYTES = 32;
	localparam int POLL_BIT = 7;

	// =====================================================================
	// Clock and timing
	localparam int CLK_PERIOD_PS = 8000;
	// Least times round up
	localparam int ACCESS_NS = 90;
	localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HIZ_NS = 40;
	localparam int HIZ_CYC = (HIZ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PULSE_NS = 80;
	localparam int PULSE_CYC = (PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RECOV_NS = 500;
	localparam int RECOV_CYC = (RECOV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETUP_NS = 10;
	localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Byte load window, longest time rounds down
	localparam int BYTE_LOAD_WINDOW_US = 100;
	localparam int BYTE_LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_US * 1000000 / CLK_PERIOD_PS;
	localparam int CNT_W = 16;

	// =====================================================================
	// Host commands
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_POLL = 2'h2;

endpackage : pepw_pkg

`default_nettype wire

// ---- pepw_buf.sv ----
`timescale 1ns/1ps
`default_nettype none

// =========================================================================
// Two-entry buffer for read data toward the user
module pepw_buf (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data
);

	logic [7:0] mem_r [2];
	logic [1:0] cnt_r;
	logic rd_ptr_r;
	logic wr_ptr_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Honest flags from the occupancy count
	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data = mem_r[rd_ptr_r];

	// Pointers and count
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_r <= 2'h0;
			rd_ptr_r <= 1'b0;
			wr_ptr_r <= 1'b0;
		end else begin
			if (push) wr_ptr_r <= ~wr_ptr_r;
			if (pop) rd_ptr_r <= ~rd_ptr_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	// Storage needs no reset
	always_ff @(posedge mclk) begin
		if (push) mem_r[wr_ptr_r] <= in_data;
	end

	a_buf_no_overflow: assert property (@(posedge mclk) disable iff (!rst_n)
		cnt_r <= 2'h2) else $error("buffer count above two");

endmodule : pepw_buf

`default_nettype wire

// ---- pepw_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Memory device model, programming time shortened to PROG_CYC
module pepw_dev_model #(
	parameter int PROG_CYC = 300,
	parameter int LAT = 4
) (
	// Clock
	input wire logic mclk,
	// Device pins
	input wire logic [12:0] addr,
	input wire logic chip_select_n,
	input wire logic output_drive_enable_n,
	input wire logic write_strobe_n,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out
);
	logic [7:0] mem [0:8191];
	logic [7:0] pend [0:31];
	logic [31:0] pend_v = '0;
	logic [12:0] lat_a = '0, last_a = '0;
	logic [7:0] last_d = '0, hold = '0, rd_val;
	logic wr, rd, wr_q = 1'b0;
	int win = 0, prog = 0, loads = 0, rd_cnt = 0;
	initial for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
	// Mode decode
	assign wr = !chip_select_n && !write_strobe_n && output_drive_enable_n;
	assign rd = !chip_select_n && !output_drive_enable_n;
	assign rd_val = (prog > 0 && addr == last_a) ? {~last_d[7], last_d[6:0]} : mem[addr];
	// Released lines show the inverse, so a stale value never passes
	assign dq_out = (rd && rd_cnt >= LAT) ? rd_val : ~hold;
	// Loads, window and self-timed programming
	always @(posedge mclk) begin
		wr_q <= wr;
		rd_cnt <= rd ? rd_cnt + 1 : 0;
		if (rd) hold <= rd_val;
		if (win > 0) win <= win - 1;
		if (prog > 0) prog <= prog - 1;
		if (prog == 0 && wr && !wr_q) begin
			lat_a <= addr;
			win <= pepw_pkg::BYTE_LOAD_WINDOW_CYC;
		end else if (prog == 0 && !wr && wr_q && loads < pepw_pkg::PAGE_BYTES) begin
			pend[lat_a[4:0]] <= dq_in;
			pend_v[lat_a[4:0]] <= 1'b1;
			last_a <= lat_a;
			last_d <= dq_in;
			loads <= loads + 1;
		end else if (win == 1) begin
			prog <= PROG_CYC;
		end
		if (prog == 1) begin
			for (int i = 0; i < 32; i++) if (pend_v[i]) mem[{last_a[12:5], 5'(i)}] <= pend[i];
			pend_v <= '0;
			loads <= 0;
		end
	end
endmodule : pepw_dev_model

`default_nettype wire

// ---- pepw_host_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Bench: page write, refusals, polling and buffered read-back
module pepw_host_bench;
	logic mclk, rst_n, cmd_valid, cmd_last, rd_ready, stall, took, perr;
	logic cmd_ready, rd_valid, busy, page_err, cs_n, oe_n, we_n, dq_oe;
	logic [1:0] cmd_op;
	logic [12:0] cmd_addr, mem_addr;
	logic [7:0] cmd_wdata, rd_data, dq_o, dev_dq, dq_w;
	logic [7:0] wd [0:31];
	logic [15:0] m;
	logic [15:0] expq [$];
	int n_errors, check_count, polls, k, seed;
	localparam logic [12:0] BASE = 13'h0140;
	// Wire level: host drives while enabled, else the device
	assign dq_w = dq_oe ? dq_o : dev_dq;
	pepw_host DUT (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_last(cmd_last),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy),
		.page_err(page_err), .mem_addr(mem_addr), .chip_select_n(cs_n),
		.output_drive_enable_n(oe_n), .write_strobe_n(we_n), .mem_dq_i(dq_w),
		.mem_dq_o(dq_o), .mem_dq_oe(dq_oe));
	pepw_dev_model #(.PROG_CYC(300), .LAT(4)) u_dev (.mclk(mclk), .addr(mem_addr),
		.chip_select_n(cs_n), .output_drive_enable_n(oe_n), .write_strobe_n(we_n),
		.dq_in(dq_w), .dq_out(dev_dq));
	// Clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	// One command, held until taken or the bound runs out
	task automatic issue(input logic [1:0] op, input logic [12:0] a, input logic [7:0] d,
		input int lim);
		@(negedge mclk);
		took = 1'b0;
		perr = 1'b0;
		{cmd_op, cmd_addr, cmd_wdata, cmd_valid} = {op, a, d, 1'b1};
		// Ready is combinational: read it at the edge that takes the command
		for (int i = 0; i < lim && !took; i++) begin
			@(posedge mclk);
			perr |= (page_err === 1'b1);
			took = (cmd_ready === 1'b1);
		end
		@(negedge mclk);
		cmd_valid = 1'b0;
	endtask : issue
	// Random consumer stalls
	always @(negedge mclk) rd_ready <= stall ? 1'b0 : ($urandom % 4 != 0);
	// Result and pin watcher
	always @(posedge mclk) begin
		if (rst_n && rd_valid === 1'b1 && rd_ready) begin
			m = expq.size() ? expq.pop_front() : 16'hFF00;
			check("rd_data", rd_data & m[15:8], m[7:0]);
		end
		if (rst_n && oe_n === 1'b0) check("oe_in_read", {5'h00, dq_oe, we_n, cs_n}, 8'h02);
		if (rst_n && we_n === 1'b0) check("we_ctl", {6'h00, oe_n, cs_n}, 8'h02);
	end
	// Main sequence
	initial begin
		seed = $urandom(7477);
		{n_errors, check_count, cmd_valid, cmd_op, cmd_addr, cmd_wdata, cmd_last} = '0;
		{stall, rst_n} = 2'h2;
		repeat (5) @(posedge mclk);
		@(negedge mclk) rst_n = 1'b1;
		for (int i = 0; i < 32; i++) begin
			if (i == 16) begin
				issue(pepw_pkg::CMD_WRITE, 13'h0020, 8'hA5, 20);
				check("mid_page", {6'h00, took, perr}, 8'h01);
			end
			wd[i] = $urandom;
			cmd_last = (i == 31);
			issue(pepw_pkg::CMD_WRITE, BASE + 13'(i), wd[i], 200);
			check("load_taken", {7'h00, took}, 8'h01);
		end
		issue(pepw_pkg::CMD_WRITE, BASE, 8'h5A, 20);
		check("load33", {6'h00, took, perr}, 8'h01);
		issue(pepw_pkg::CMD_WRITE, 13'h0020, 8'hA5, 20);
		check("other_page", {6'h00, took, perr}, 8'h01);
		for (k = 0; k < 14000 && busy !== 1'b1; k++) @(negedge mclk);
		check("busy_up", {busy, 6'h00, k > pepw_pkg::BYTE_LOAD_WINDOW_CYC / 2}, 8'h81);
		issue(pepw_pkg::CMD_WRITE, BASE, 8'h00, 20);
		check("write_busy", {7'h00, took}, 8'h00);
		stall = 1'b0;
		for (polls = 0; busy === 1'b1 && polls < 60; polls++) begin
			expq.push_back({8'h7F, 1'b0, wd[31][6:0]});
			issue(pepw_pkg::CMD_POLL, BASE + 13'h1F, 8'h00, 200);
		end
		check("poll_end", {busy, 6'h00, polls > 2}, 8'h01);
		// Drain the last poll results so the buffer starts empty
		for (k = 0; k < 500 && expq.size() > 0; k++) @(negedge mclk);
		stall = 1'b1;
		for (int i = 0; i < 3; i++) begin
			if (i < 2) expq.push_back({8'hFF, wd[i]});
			issue(pepw_pkg::CMD_READ, BASE + 13'(i), 8'h00, i < 2 ? 200 : 40);
			check("buf_room", {7'h00, took}, {7'h00, i < 2});
		end
		stall = 1'b0;
		for (int i = 2; i < 33; i++) begin
			expq.push_back({8'hFF, i < 32 ? wd[i] : 8'hFF});
			issue(pepw_pkg::CMD_READ, i < 32 ? BASE + 13'(i) : 13'h1FFF, 8'h00, 200);
		end
		for (k = 0; k < 500 && expq.size() > 0; k++) @(negedge mclk);
		check("left", 8'(expq.size()), 8'h00);
		wrap_up();
	end
endmodule : pepw_host_bench

`default_nettype wire
